// *** hw/acs_pkg.sv ***
// constants, register layout and carrier types for the converter sequencer
// assumes a 32-bit apb master and an analog core with its own successive approximation logic
// Overview of operation
// - interrupt request after every non-discarded conversion when enabled
// - request goes to cpu or dma by select
// - result read or control write withdraws request
// - done bit read-only, set per completion
// - control write or result read clears done
// - with interrupts on, select bit is storage
// - reset clears enable, continuous and select
// - continuous mode converts back to back
// - single mode: one conversion per control write
// - five bit channel, codes 0-5 port pins
// - channel codes select high and low reference
// - all ones channel code powers converter down
// - first conversion after power-up is discarded
// - keeps converting in wait, request wakes cpu
// - stop mode aborts conversion, block inactive
// - stop exit resumes, first conversion discarded
// - result register loaded at each completion
// - prescaler divides by 1,2,4,8, else 16
// - source select: 1 bus clock, 0 oscillator
// - conversion takes 16 or 17 converter clocks
// - control write starts a conversion
// - selected port pin forced input, reads zero
package acs_pkg;

  localparam logic [7:0] ACS_OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ACS_OFS_RESULT = 8'h04;
  localparam logic [7:0] ACS_OFS_CLOCK_CONFIG = 8'h08;

  localparam int ACS_BIT_DONE_SEL = 7;
  localparam int ACS_BIT_IRQ_EN = 6;
  localparam int ACS_BIT_CONT = 5;
  localparam int ACS_CH_MSB = 4;
  localparam int ACS_DIV_MSB = 7;
  localparam int ACS_DIV_LSB = 5;
  localparam int ACS_BIT_SRC = 4;

  localparam logic [4:0] ACS_CH_RESET = 5'h1F;
  localparam logic [4:0] ACS_CH_POWER_OFF = 5'h1F;
  localparam logic [4:0] ACS_CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] ACS_CH_REF_LOW = 5'h1E;
  localparam logic [4:0] ACS_CH_LAST_PORT = 5'h05;
  localparam logic [2:0] ACS_DIV_RESET = 3'h0;
  localparam logic ACS_SRC_RESET = 1'b0;
  localparam logic [7:0] ACS_RESULT_RESET = 8'h00;

  localparam logic [4:0] ACS_CONV_CYCLES = 5'h10;

  typedef enum {
    ACS_IDLE,
    ACS_WAIT_TICK,
    ACS_CONVERT
  } acs_state_type;

  typedef struct packed {
    logic irq_enable;
    logic continuous;
    logic [4:0] channel;
  } acs_control_type;

  typedef struct packed {
    logic power;
    logic start;
    logic clk_tick;
    logic [4:0] channel;
  } acs_core_type;

endpackage : acs_pkg

// *** hw/acs_sequencer.sv ***
// apb slave and conversion sequencer for an 8-bit successive approximation converter
// assumes the analog core converts on core.clk_tick pulses and holds its result until the next start
`timescale 1ns/10ps
`default_nettype none

module acs_sequencer
  import acs_pkg::*;
#(
  parameter int PORT_CHANNELS = 6
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic oscillator_ref_clock_i,
  input wire logic stop_mode_i,
  input wire logic [7:0] core_result_i,
  output acs_core_type core_o,
  output logic [PORT_CHANNELS-1:0] port_override_o,
  output logic irq_cpu_o,
  output logic dma_req_o
);

  // control and configuration state
  acs_control_type ctrl;
  logic done_sel;
  logic [2:0] clock_divider_sel;
  logic clock_source_sel;
  logic [7:0] conv_result;

  // sequencer state
  acs_state_type state;
  logic [4:0] conv_cnt;
  logic [3:0] pre_cnt;
  logic start_pend;
  logic discard;
  logic stop_q;
  logic stop_aborted;
  logic osc_meta;
  logic osc_sync;
  logic osc_last;

  // apb decode
  wire logic setup = psel_i & ~penable_i;
  wire logic access = psel_i & penable_i & pready_o;
  wire logic hit_scr = paddr_i == ACS_OFS_STATUS_CONTROL;
  wire logic hit_res = paddr_i == ACS_OFS_RESULT;
  wire logic hit_clk = paddr_i == ACS_OFS_CLOCK_CONFIG;
  wire logic mapped = hit_scr | hit_res | hit_clk;
  wire logic wr_scr = access & pwrite_i & hit_scr;
  wire logic wr_clk = access & pwrite_i & hit_clk;
  wire logic rd_res = access & ~pwrite_i & hit_res;
  wire logic [7:0] scr_view = {done_sel, ctrl.irq_enable, ctrl.continuous, ctrl.channel};
  wire logic [7:0] clk_view = {clock_divider_sel, clock_source_sel, 4'h0};
  wire logic [7:0] rd_byte = hit_scr ? scr_view :
                             hit_res ? conv_result :
                             hit_clk ? clk_view : 8'h00;

  // written control fields
  wire logic [4:0] wr_channel = pwdata_i[ACS_CH_MSB:0];
  wire logic wr_irq_en = pwdata_i[ACS_BIT_IRQ_EN];
  wire logic wr_cont = pwdata_i[ACS_BIT_CONT];
  wire logic wr_sel = pwdata_i[ACS_BIT_DONE_SEL];

  // converter clock: source edge then prescaler
  wire logic osc_edge = osc_sync & ~osc_last;
  wire logic src_edge = clock_source_sel ? 1'b1 : osc_edge;
  wire logic [3:0] div_last = clock_divider_sel[2] ? 4'hF :
                              clock_divider_sel[1:0] == 2'h3 ? 4'h7 :
                              clock_divider_sel[1:0] == 2'h2 ? 4'h3 :
                              clock_divider_sel[1:0] == 2'h1 ? 4'h1 : 4'h0;
  wire logic tick = src_edge & (pre_cnt >= div_last);

  wire logic powered_off = ctrl.channel == ACS_CH_POWER_OFF;
  wire logic stop_enter = stop_mode_i & ~stop_q;
  wire logic stop_exit = ~stop_mode_i & stop_q;
  wire logic conv_end = (state == ACS_CONVERT) & tick & (conv_cnt == ACS_CONV_CYCLES - 5'h01);
  wire logic complete = conv_end & ~discard & ~stop_mode_i;
  // leaving the power-off code needs one throwaway conversion
  wire logic wake_from_off = wr_scr & powered_off & (wr_channel != ACS_CH_POWER_OFF);
  wire logic [4:0] next_channel = wr_scr ? wr_channel : ctrl.channel;
  wire logic next_off = next_channel == ACS_CH_POWER_OFF;
  wire logic next_cont = wr_scr ? wr_cont : ctrl.continuous;
  wire logic next_irq_en = wr_scr ? wr_irq_en : ctrl.irq_enable;

  // irq pending: completion sets, result read or control write withdraws, set wins
  logic irq_pend;
  wire logic next_irq_pend = (complete & ctrl.irq_enable) | (irq_pend & ~rd_res & ~wr_scr);
  // with interrupts off the bit is the done flag, so a result read clears it as well
  wire logic rd_clears_done = rd_res & ~ctrl.irq_enable;
  wire logic next_sel_bit = wr_scr ? (wr_irq_en ? wr_sel : 1'b0) :
                            rd_clears_done ? 1'b0 : done_sel;

  // port pin forced to analog input while selected
  logic [PORT_CHANNELS-1:0] next_override;
  always_comb begin
    next_override = '0;
    for (int i = 0; i < PORT_CHANNELS; i++) begin
      if (!next_off && next_channel == 5'(i)) begin
        next_override[i] = 1'b1;
      end
    end
  end

  // apb answer: no wait state, registered from the setup phase so every bus output is a flop
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & ~mapped;
      prdata_o <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl.irq_enable <= 1'b0;
      ctrl.continuous <= 1'b0;
      ctrl.channel <= ACS_CH_RESET;
      clock_divider_sel <= ACS_DIV_RESET;
      clock_source_sel <= ACS_SRC_RESET;
    end else begin
      if (wr_scr) begin
        ctrl.irq_enable <= wr_irq_en;
        ctrl.continuous <= wr_cont;
        ctrl.channel <= wr_channel;
      end
      if (wr_clk) begin
        clock_divider_sel <= pwdata_i[ACS_DIV_MSB:ACS_DIV_LSB];
        clock_source_sel <= pwdata_i[ACS_BIT_SRC];
      end
    end
  end

  // done flag / dma select
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_sel <= 1'b0;
    end else if (complete & ~ctrl.irq_enable & ~next_irq_en) begin
      done_sel <= 1'b1;
    end else begin
      done_sel <= next_sel_bit;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_result <= ACS_RESULT_RESET;
    end else if (complete) begin
      conv_result <= core_result_i;
    end
  end

  // interrupt routing, usable as a wake source in wait mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_pend <= 1'b0;
      irq_cpu_o <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      irq_pend <= next_irq_pend;
      irq_cpu_o <= next_irq_pend & next_irq_en & ~next_sel_bit;
      dma_req_o <= next_irq_pend & next_irq_en & next_sel_bit;
    end
  end

  // oscillator reference arrives asynchronously
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      osc_meta <= oscillator_ref_clock_i;
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
      stop_q <= stop_mode_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_cnt <= 4'h0;
    end else if (stop_mode_i | powered_off) begin
      pre_cnt <= 4'h0;
    end else if (tick) begin
      pre_cnt <= 4'h0;
    end else if (src_edge) begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  // a single conversion aborted by stop is remembered so it resumes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_aborted <= 1'b0;
    end else if (stop_enter) begin
      stop_aborted <= (state != ACS_IDLE) | start_pend;
    end else if (stop_exit) begin
      stop_aborted <= 1'b0;
    end
  end

  // throwaway conversion after power-off or stop
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      discard <= 1'b0;
    end else if (wake_from_off | stop_exit) begin
      discard <= 1'b1;
    end else if (conv_end) begin
      discard <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_pend <= 1'b0;
    end else if (stop_mode_i | next_off) begin
      start_pend <= 1'b0;
    end else if (wr_scr) begin
      start_pend <= 1'b1;
    end else if (stop_exit & (ctrl.continuous | stop_aborted)) begin
      start_pend <= 1'b1;
    end else if (state == ACS_WAIT_TICK & tick) begin
      start_pend <= 1'b0;
    end
  end

  // sequencer: a write restarts, the start aligns to the next tick, so 16 or 17 ticks
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ACS_IDLE;
      conv_cnt <= 5'h00;
    end else if (stop_mode_i | next_off | wr_scr) begin
      state <= (stop_mode_i | next_off) ? ACS_IDLE : ACS_WAIT_TICK;
      conv_cnt <= 5'h00;
    end else begin
      case (state)
        ACS_IDLE: begin
          if (start_pend) begin
            state <= ACS_WAIT_TICK;
          end
        end
        ACS_WAIT_TICK: begin
          if (tick) begin
            state <= ACS_CONVERT;
            conv_cnt <= 5'h00;
          end
        end
        ACS_CONVERT: begin
          if (conv_end) begin
            conv_cnt <= 5'h00;
            state <= (ctrl.continuous | discard) ? ACS_CONVERT : ACS_IDLE;
          end else if (tick) begin
            conv_cnt <= conv_cnt + 5'h01;
          end
        end
        default: begin
          state <= ACS_IDLE;
        end
      endcase
    end
  end

  // core drive
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_o <= '0;
      port_override_o <= '0;
    end else begin
      core_o.power <= ~next_off & ~stop_mode_i;
      core_o.start <= (state == ACS_WAIT_TICK & tick & ~wr_scr & ~stop_mode_i) |
                      (conv_end & (ctrl.continuous | discard) & ~wr_scr & ~stop_mode_i);
      core_o.clk_tick <= tick & ~stop_mode_i;
      core_o.channel <= next_channel;
      port_override_o <= next_override;
    end
  end

endmodule : acs_sequencer

`default_nettype wire

// *** testbench/acs_sequencer_sva.sv ***
// assertions on the converter sequencer ports
// assumes binding onto acs_sequencer, one bus clock domain
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_sva
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic stop_mode_i,
  input wire acs_core_type core_o,
  input wire logic irq_cpu_o,
  input wire logic dma_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic acc = psel_i && penable_i && pready_o;
  wire logic wr_scr = acc && pwrite_i && paddr_i == ACS_OFS_STATUS_CONTROL;
  wire logic rd_res = acc && !pwrite_i && paddr_i == ACS_OFS_RESULT;
  wire logic no_req = !irq_cpu_o && !dma_req_o;
  property p_ready; psel_i && !penable_i |=> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("access not answered");
  property p_route; !(irq_cpu_o && dma_req_o); endproperty
  a_route: assert property (p_route) else $error("request on both routes");
  property p_read_clr; rd_res |=> no_req; endproperty
  a_read_clr: assert property (p_read_clr) else $error("request kept after result read");
  property p_write_clr; wr_scr |=> no_req; endproperty
  a_write_clr: assert property (p_write_clr) else $error("request kept after control write");
  property p_off; wr_scr && pwdata_i[4:0] == ACS_CH_POWER_OFF |-> ##2 !core_o.power; endproperty
  a_off: assert property (p_off) else $error("core powered with off code");
  property p_powered; core_o.start |-> core_o.power; endproperty
  a_powered: assert property (p_powered) else $error("start while unpowered");
  property p_stop; stop_mode_i && $past(stop_mode_i) |-> !core_o.start && !core_o.clk_tick; endproperty
  a_stop: assert property (p_stop) else $error("core active in stop");
  // a write of a channel other than the off code with stop mode low must launch a conversion within the slowest prescale
  property p_start; wr_scr && pwdata_i[4:0] != ACS_CH_POWER_OFF && !stop_mode_i |-> ##[1:300] core_o.start;
  endproperty
  a_start: assert property (p_start) else $error("no start after control write");
  c_cpu: cover property (irq_cpu_o);
  c_dma: cover property (dma_req_o);
  c_stop: cover property (stop_mode_i && core_o.power);
endmodule : acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva u_acs_sequencer_sva (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .stop_mode_i(stop_mode_i), .core_o(core_o), .irq_cpu_o(irq_cpu_o), .dma_req_o(dma_req_o));
`default_nettype wire

// *** testbench/acs_analog_core.sv ***
// behavioural analog core: sample and hold, then 16 converter clocks
// assumes start and clk_tick pulses from the sequencer in the bus domain
`timescale 1ns/10ps
`default_nettype none
module acs_analog_core
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire acs_core_type core_i,
  input wire logic [7:0] level_i,
  output logic [7:0] result_o
);
  logic [7:0] held;
  logic [4:0] ticks;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      held <= 8'h00;
      ticks <= 5'h00;
    end else if (core_i.start) begin
      held <= level_i;
      ticks <= {4'h0, core_i.clk_tick};
    end else if (core_i.clk_tick && ticks != 5'h1F) begin
      ticks <= ticks + 5'h01;
    end
  end
  // unsettled output changes every tick so an early sample is caught
  assign result_o = (core_i.power && ticks >= 5'h0F) ? held : ~held ^ {3'h0, ticks};
endmodule : acs_analog_core
`default_nettype wire

// *** testbench/adc_sequencer_control_bench.sv ***
// self-checking bench: apb master, analog core model, result queue model
// assumes acs_pkg, acs_sequencer and acs_analog_core compiled before
`timescale 1ns/10ps
`default_nettype none
module adc_sequencer_control_bench;
  import acs_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, osc = 1'b0, stop = 1'b0;
  logic e, pready, pslverr, irq_cpu, dma_req;
  logic [7:0] paddr = 8'h00, level = 8'h00, res;
  logic [5:0] ovr;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'hDBA3;
  logic [7:0] model_q[$];
  acs_core_type core;
  int mismatches = 0, total_checks = 0, cycles = 0, n;
  logic [7:0] cfg[7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
  logic [7:0] chs[7] = '{8'h00, 8'h05, 8'h1D, 8'h1E, 8'h02, 8'h04, 8'h01};
  int dv[7] = '{1, 2, 4, 8, 16, 16, 9};
  acs_sequencer u_acs_sequencer (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .oscillator_ref_clock_i(osc), .stop_mode_i(stop), .core_result_i(res),
    .core_o(core), .port_override_o(ovr), .irq_cpu_o(irq_cpu), .dma_req_o(dma_req));
  acs_analog_core u_acs_analog_core (.clk_i(clk_i), .rstn_i(rstn_i), .core_i(core), .level_i(level),
    .result_o(res));
  always #4 clk_i = ~clk_i;
  // oscillator about 9.25 bus cycles, phase unrelated to the bus clock
  always #37 osc = ~osc;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic wait_req();
    n = 0;
    while (!(irq_cpu === 1'b1 || dma_req === 1'b1) && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_req
  task automatic new_level();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    level <= seed[7:0];
    model_q.push_back(seed[7:0]);
  endtask : new_level
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(ACS_OFS_STATUS_CONTROL, 32'h1F);
    rd(ACS_OFS_CLOCK_CONFIG, 32'h0);
    rd(8'h0C, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, ACS_OFS_CLOCK_CONFIG, 32'hABCD_EF1F);
    rd(ACS_OFS_CLOCK_CONFIG, 32'h10);
    $display("test registers done");
    new_level();
    apb(1'b1, ACS_OFS_STATUS_CONTROL, 32'h03);
    chk(ovr, 6'h08);
    repeat (40) begin
      apb(1'b0, ACS_OFS_STATUS_CONTROL, 32'h0);
      if (q[7] === 1'b1) break;
    end
    chk(q, 32'h83);
    rd(ACS_OFS_RESULT, model_q[$]);
    repeat (60) @(posedge clk_i);
    rd(ACS_OFS_STATUS_CONTROL, 32'h03);
    // dma select with interrupts on is set once only, to see the route, then cleared again
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ACS_OFS_STATUS_CONTROL, 32'h43 | (s << 7));
      wait_req();
      chk({irq_cpu, dma_req}, s ? 2'b01 : 2'b10);
      rd(ACS_OFS_STATUS_CONTROL, 32'h43 | (s << 7));
      rd(ACS_OFS_RESULT, model_q[$]);
      chk({irq_cpu, dma_req}, 2'b00);
    end
    $display("test single and routing done");
    for (int i = 0; i < 7; i++) begin
      new_level();
      apb(1'b1, ACS_OFS_CLOCK_CONFIG, cfg[i]);
      apb(1'b1, ACS_OFS_STATUS_CONTROL, 32'h40 | chs[i]);
      wait_req();
      chk(ovr, chs[i] < 6 ? 6'h01 << chs[i] : 6'h00);
      chk(n >= 15 * dv[i] && n <= 18 * dv[i] + 24, 1'b1);
      rd(ACS_OFS_RESULT, model_q[$]);
    end
    $display("test prescaler and channels done");
    apb(1'b1, ACS_OFS_CLOCK_CONFIG, 32'h10);
    apb(1'b1, ACS_OFS_STATUS_CONTROL, 32'h23);
    for (int i = 0; i < 2; i++) begin
      new_level();
      repeat (60) @(posedge clk_i);
      rd(ACS_OFS_STATUS_CONTROL, 32'hA3);
      rd(ACS_OFS_RESULT, model_q[$]);
    end
    apb(1'b1, ACS_OFS_STATUS_CONTROL, 32'h1F);
    repeat (2) @(posedge clk_i);
    chk(core.power, 1'b0);
    $display("test continuous done");
    apb(1'b1, ACS_OFS_STATUS_CONTROL, 32'h42);
    wait_req();
    chk(n >= 30, 1'b1);
    rd(ACS_OFS_RESULT, model_q[$]);
    apb(1'b1, ACS_OFS_STATUS_CONTROL, 32'h42);
    repeat (6) @(posedge clk_i);
    stop <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk({irq_cpu, dma_req}, 2'b00);
    stop <= 1'b0;
    wait_req();
    chk(n >= 30, 1'b1);
    rd(ACS_OFS_RESULT, model_q[$]);
    $display("test power and stop done");
    conclude();
  end
endmodule : adc_sequencer_control_bench
`default_nettype wire
